// ### pkg/tws_params.svh
// constants of the two-wire slave transmitter
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

`define TWS_OFF_DATA 3'h0
`define TWS_OFF_OWN 3'h1
`define TWS_OFF_CTRL 3'h2
`define TWS_OFF_STAT 3'h3
`define TWS_OFF_IST 3'h4
`define TWS_OFF_ICLR 3'h5
`define TWS_OFF_IEN 3'h6

`define TWS_B_FLAG 7
`define TWS_B_ACK 6
`define TWS_B_STA 5
`define TWS_B_STO 4
`define TWS_B_WC 3
`define TWS_B_EN 2
`define TWS_B_IE 0

`define TWS_EV_FLAG 0
`define TWS_EV_STOP 1
`define TWS_EV_WC 2

`define TWS_RST_OWN 8'h00
`define TWS_RST_DATA 8'hff
`define TWS_GC_ADDR 7'h00

`define TWS_ST_OWN_W 8'h60
`define TWS_ST_GC_W 8'h70
`define TWS_ST_OWN_R 8'ha8
`define TWS_ST_ARB_R 8'hb0
`define TWS_ST_DATA_ACK 8'hb8
`define TWS_ST_DATA_NACK 8'hc0
`define TWS_ST_LAST_ACK 8'hc8
`define TWS_ST_NONE 8'hf8

`endif

// ### pkg/tws_pkg.sv
// types of the two-wire slave transmitter
package tws_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_TXB = 7'h08,
    S_MACK = 7'h10,
    S_HOLD = 7'h20,
    S_NADR = 7'h40
  } tws_state_t;

  typedef struct packed {
    tws_state_t st;
    logic flag;
    logic ack_en;
    logic sta;
    logic sto;
    logic wc;
    logic en;
    logic ie;
    logic [7:0] own;
    logic [7:0] dreg;
    logic [7:0] stat;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic ph;
    logic sda_drv;
    logic last;
    logic mack;
    logic arb;
    logic rx;
    logic gc;
    logic start_pend;
    logic mst_start;
    logic [2:0] ist;
    logic [2:0] ien;
    logic [7:0] rdata;
  } tws_regs_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_line_t;
endpackage : tws_pkg

// ### logic/tws_sync.sv
// two-flop synchroniser for one bus line
`timescale 1ns/1ps
module tws_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // line in and out
  input wire logic d,
  output logic q
);
  logic [1:0] r;
  logic [1:0] next_r;

  always_comb
  begin
    next_r = {r[0], d};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= {RST_VAL, RST_VAL};
    else
      r <= next_r;
  end

  assign q = r[1];
endmodule : tws_sync

// ### logic/tws_cond.sv
// edge, start and stop detection on the synchronised bus lines
`timescale 1ns/1ps
module tws_cond
  import tws_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised lines
  input wire logic scl,
  input wire logic sda,
  // one-cycle events
  output logic scl_rise,
  output logic scl_fall,
  output logic start,
  output logic stop
);
  tws_line_t r;
  tws_line_t next_r;

  always_comb
  begin
    next_r.scl = scl;
    next_r.sda = sda;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= tws_line_t'{scl: 1'b1, sda: 1'b1};
    else
      r <= next_r;
  end

  assign scl_rise = scl & ~r.scl;
  assign scl_fall = ~scl & r.scl;
  // sda moving while scl stays high marks a frame boundary
  assign start = scl & r.scl & r.sda & ~sda;
  assign stop = scl & r.scl & ~r.sda & sda;
endmodule : tws_cond

// ### logic/tws_slave_tx.sv
// two-wire slave transmitter with register port and interrupt logic
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_slave_tx (
  // system
  input wire logic MCLK,
  input wire logic RESET_N,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // two-wire bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SCL_O,
  output logic SCL_OE,
  output logic SDA_O,
  output logic SDA_OE,
  // chip side
  input wire logic ARB_LOST,
  input wire logic SLEEP,
  output logic WAKE,
  output logic MST_START,
  output logic IRQ
);
  import tws_pkg::*;

  tws_regs_t r;
  tws_regs_t next_r;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // both bus lines pass two flops before any logic reads them
  tws_sync #(
    .RST_VAL(1'b1)
  ) u_sync_scl (
    .clk(MCLK),
    .rst_n(RESET_N),
    .d(SCL_I),
    .q(scl_s)
  );

  tws_sync #(
    .RST_VAL(1'b1)
  ) u_sync_sda (
    .clk(MCLK),
    .rst_n(RESET_N),
    .d(SDA_I),
    .q(sda_s)
  );

  tws_cond u_cond (
    .clk(MCLK),
    .rst_n(RESET_N),
    .scl(scl_s),
    .sda(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start(bus_start),
    .stop(bus_stop)
  );

  always_comb
  begin
    logic [2:0] ev;
    logic flag_clr;
    logic recog;
    logic [7:0] abyte;
    logic own_hit;
    logic gc_hit;
    logic tx_stat;
    ev = 3'h0;
    flag_clr = 1'b0;
    next_r = r;
    next_r.mst_start = 1'b0;
    // read data stand for one cycle only, zero otherwise
    next_r.rdata = 8'h00;
    abyte = {r.shreg[6:0], sda_s};
    // an all-zero address byte is the general call, never an own-address match
    own_hit = (abyte[7:1] == r.own[7:1]) && (abyte[7:1] != `TWS_GC_ADDR);
    gc_hit = (abyte[7:1] == `TWS_GC_ADDR) && r.own[0] && !abyte[0];
    // address recognition follows acknowledge_enable live
    recog = r.en & r.ack_en;
    // status codes after which software loads a byte to send
    tx_stat = (r.stat == `TWS_ST_OWN_R) || (r.stat == `TWS_ST_ARB_R)
      || (r.stat == `TWS_ST_DATA_ACK);

    if (RD)
    begin
      case (ADDR)
        `TWS_OFF_DATA: next_r.rdata = r.dreg;
        `TWS_OFF_OWN: next_r.rdata = r.own;
        `TWS_OFF_CTRL: next_r.rdata = {r.flag, r.ack_en, r.sta, r.sto, r.wc, r.en,
          1'b0, r.ie};
        // prescaler bits read as zero
        `TWS_OFF_STAT: next_r.rdata = r.flag ? r.stat : `TWS_ST_NONE;
        `TWS_OFF_IST: next_r.rdata = {5'h00, r.ist};
        `TWS_OFF_IEN: next_r.rdata = {5'h00, r.ien};
        default: next_r.rdata = 8'h00;
      endcase
    end

    if (WR)
    begin
      case (ADDR)
        `TWS_OFF_DATA:
        begin
          if (r.flag)
          begin
            next_r.dreg = WDATA;
            next_r.wc = 1'b0;
          end
          else
          begin
            next_r.wc = 1'b1;
            ev[`TWS_EV_WC] = 1'b1;
          end
        end
        `TWS_OFF_OWN: next_r.own = WDATA;
        `TWS_OFF_CTRL:
        begin
          next_r.ack_en = WDATA[`TWS_B_ACK];
          next_r.sta = WDATA[`TWS_B_STA];
          next_r.sto = WDATA[`TWS_B_STO];
          next_r.en = WDATA[`TWS_B_EN];
          next_r.ie = WDATA[`TWS_B_IE];
          flag_clr = WDATA[`TWS_B_FLAG] & r.flag;
        end
        `TWS_OFF_ICLR: next_r.ist = r.ist & ~WDATA[2:0];
        `TWS_OFF_IEN: next_r.ien = WDATA[2:0];
        default: next_r.ist = next_r.ist;
      endcase
    end

    if (flag_clr)
      next_r.flag = 1'b0;

    if (!r.en)
    begin
      next_r.st = S_IDLE;
      next_r.start_pend = 1'b0;
      // a disabled unit lets go of sda only with scl low, so no false stop appears
      if (!scl_s)
        next_r.sda_drv = 1'b0;
    end
    // a start or stop seen while scl is stretched is ignored
    else if (bus_stop && r.st != S_HOLD)
    begin
      next_r.st = S_IDLE;
      next_r.sda_drv = 1'b0;
      next_r.arb = 1'b0;
      ev[`TWS_EV_STOP] = 1'b1;
    end
    else if (bus_start && r.st != S_HOLD)
    begin
      next_r.st = S_ADDR;
      next_r.bitcnt = 3'h0;
      next_r.sda_drv = 1'b0;
    end
    else
    begin
      case (r.st)
        S_IDLE:
        begin
          // queued start goes out once the bus is free
          if (r.start_pend)
          begin
            next_r.mst_start = 1'b1;
            next_r.start_pend = 1'b0;
            // a start_request written in this very cycle is a new one and stays
            if (!(WR && ADDR == `TWS_OFF_CTRL))
              next_r.sta = 1'b0;
          end
        end
        S_ADDR:
        begin
          if (scl_rise)
          begin
            next_r.shreg = abyte;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7)
            begin
              next_r.ph = 1'b0;
              if (recog && own_hit)
              begin
                next_r.st = S_AACK;
                next_r.rx = ~abyte[0];
                next_r.gc = 1'b0;
              end
              // general call is only answered as a write
              else if (recog && gc_hit)
              begin
                next_r.st = S_AACK;
                next_r.rx = 1'b1;
                next_r.gc = 1'b1;
              end
              else
                next_r.st = S_NADR;
            end
          end
        end
        S_AACK:
        begin
          if (scl_fall)
          begin
            // eighth fall pulls sda low for the acknowledge, ninth fall stretches scl
            if (!r.ph)
            begin
              next_r.sda_drv = 1'b1;
              next_r.ph = 1'b1;
            end
            else
            begin
              next_r.sda_drv = 1'b0;
              next_r.ph = 1'b0;
              next_r.flag = 1'b1;
              next_r.st = S_HOLD;
              next_r.arb = 1'b0;
              if (r.rx)
                next_r.stat = r.gc ? `TWS_ST_GC_W : `TWS_ST_OWN_W;
              else if (r.arb)
                next_r.stat = `TWS_ST_ARB_R;
              else
                next_r.stat = `TWS_ST_OWN_R;
            end
          end
        end
        S_HOLD:
        begin
          if (flag_clr)
          begin
            if (tx_stat)
            begin
              // load the byte and put its msb out while scl is still held low
              next_r.shreg = r.dreg;
              next_r.last = ~next_r.ack_en;
              next_r.bitcnt = 3'h0;
              next_r.sda_drv = ~r.dreg[7];
              next_r.st = S_TXB;
            end
            else
            begin
              // write-direction and final states end not addressed
              next_r.st = S_NADR;
              next_r.start_pend = next_r.sta;
            end
            // stop_request drops the transfer and leaves both lines released
            if (next_r.sto)
            begin
              next_r.sto = 1'b0;
              next_r.sda_drv = 1'b0;
              next_r.st = S_NADR;
            end
          end
        end
        S_TXB:
        begin
          if (scl_fall)
          begin
            if (r.bitcnt == 3'h7)
            begin
              // let go of sda for the master's acknowledge
              next_r.sda_drv = 1'b0;
              next_r.st = S_MACK;
            end
            else
            begin
              // next bit goes out right after scl has fallen
              next_r.shreg = {r.shreg[6:0], 1'b0};
              next_r.sda_drv = ~r.shreg[6];
              next_r.bitcnt = r.bitcnt + 3'h1;
            end
          end
        end
        S_MACK:
        begin
          // the master's answer is taken at the rising edge of the ninth clock
          if (scl_rise)
            next_r.mack = ~sda_s;
          if (scl_fall)
          begin
            next_r.flag = 1'b1;
            next_r.st = S_HOLD;
            if (!r.mack)
              next_r.stat = `TWS_ST_DATA_NACK;
            else if (r.last)
              next_r.stat = `TWS_ST_LAST_ACK;
            else
              next_r.stat = `TWS_ST_DATA_ACK;
          end
        end
        S_NADR:
        begin
          // not addressed: sda stays released, master reads ones
          next_r.sda_drv = 1'b0;
        end
        default:
        begin
          next_r.st = S_IDLE;
          next_r.sda_drv = 1'b0;
        end
      endcase
    end

    // arbitration loss is latched last so it wins over a clear in the same cycle
    if (ARB_LOST)
      next_r.arb = 1'b1;

    if (next_r.flag && !r.flag)
      ev[`TWS_EV_FLAG] = 1'b1;
    // new events win over a clear written in the same cycle
    next_r.ist = next_r.ist | ev;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      r <= tws_regs_t'{st: S_IDLE, own: `TWS_RST_OWN, dreg: `TWS_RST_DATA,
        stat: `TWS_ST_NONE, default: '0};
    else
      r <= next_r;
  end

  // data_register is never refilled from the bus, so nothing relies on it after wake
  assign RDATA = r.rdata;
  assign SCL_O = 1'b0;
  // scl is stretched for the whole hold, also while the part sleeps
  assign SCL_OE = (r.st == S_HOLD);
  assign SDA_O = 1'b0;
  assign SDA_OE = r.sda_drv;
  assign WAKE = SLEEP & r.flag;
  assign MST_START = r.mst_start;
  // status events need their enable bit, the flag needs interrupt_enable
  assign IRQ = (|(r.ist & r.ien)) | (r.flag & r.ie);
endmodule : tws_slave_tx

// ### tb/tws_slave_tx_assertions.sv
// port assertions of the two-wire slave transmitter
`timescale 1ns/1ps
module tws_slave_tx_assertions (
  // system
  input wire logic MCLK,
  input wire logic RESET_N,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // bus and chip side
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SCL_O,
  input wire logic SCL_OE,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic SLEEP,
  input wire logic WAKE,
  input wire logic MST_START
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  // flag-clearing write to bus_control
  wire logic clr = WR && ADDR == 3'h2 && WDATA[7];
  property p_wake;
    WAKE |-> SLEEP && SCL_OE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without hold");
  property p_hold;
    SCL_OE && !clr |=> SCL_OE;
  endproperty
  a_hold: assert property (p_hold) else $error("hold dropped early");
  property p_rel;
    clr && SCL_OE |=> !SCL_OE;
  endproperty
  a_rel: assert property (p_rel) else $error("hold kept after clear");
  property p_grab;
    $rose(SCL_OE) |-> !$past(SCL_I);
  endproperty
  a_grab: assert property (p_grab) else $error("clock grabbed while high");
  property p_sda;
    $changed(SDA_OE) |-> !$past(SCL_I);
  endproperty
  a_sda: assert property (p_sda) else $error("data moved with clock high");
  property p_idle;
    RD && ADDR == 3'h3 && !SCL_OE |=> RDATA == 8'hf8;
  endproperty
  a_idle: assert property (p_idle) else $error("idle status wrong");
  property p_valid;
    RD && ADDR == 3'h3 && SCL_OE |=> RDATA inside {8'h60, 8'h70, 8'ha8, 8'hb0, 8'hb8, 8'hc0, 8'hc8};
  endproperty
  a_valid: assert property (p_valid) else $error("held status invalid");
  property p_start;
    MST_START |-> SCL_I && SDA_I ##1 !MST_START;
  endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
  property p_od;
    !SCL_O && !SDA_O;
  endproperty
  a_od: assert property (p_od) else $error("line driven high");
endmodule : tws_slave_tx_assertions
bind tws_slave_tx tws_slave_tx_assertions i_chk (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_I(SCL_I), .SDA_I(SDA_I), .SCL_O(SCL_O),
  .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SLEEP(SLEEP), .WAKE(WAKE),
  .MST_START(MST_START));

// ### tb/tws_master_model.sv
// bus master receiver model on open-drain lines
`timescale 1ns/1ps
module tws_master_model (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // pulls low when high
  output logic scl_oe,
  output logic sda_oe
);
  int stuck = 0;
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // one clock: low 500 ns, high 300 ns, waits while the slave stretches
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    #100 sda_oe = !b;
    #400 scl_oe = 1'b0;
    while (scl !== 1'b1 && n < 4000)
    begin
      #10 n++;
    end
    if (scl !== 1'b1)
      stuck++;
    #150 r = sda;
    #150 scl_oe = 1'b1;
  endtask : bit_io
  task automatic start_c;
    #800 sda_oe = 1'b1;
    #300 scl_oe = 1'b1;
  endtask : start_c
  task automatic stop_c;
    #100 sda_oe = 1'b1;
    #400 scl_oe = 1'b0;
    #300 sda_oe = 1'b0;
    #800;
  endtask : stop_c
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(a, ar);
  endtask : xfer
endmodule : tws_master_model

// ### tb/tws_slave_tx_test.sv
// testbench of the two-wire slave transmitter
`timescale 1ns/1ps
module tws_slave_tx_test;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic ARB_LOST = 1'b0;
  logic SLEEP = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA;
  logic SCL_O, SCL_OE, SDA_O, SDA_OE, WAKE, MST_START, IRQ, m_scl, m_sda, ak;
  logic [6:0] own;
  logic [7:0] rv;
  int bad_count = 0;
  int checks = 0;
  int seed = 951;
  int starts = 0;
  wire logic scl = !(SCL_OE || m_scl);
  wire logic sda = !(SDA_OE || m_sda);
  always #50 MCLK = !MCLK;
  always @(negedge MCLK)
    if (MST_START === 1'b1)
      starts++;
  tws_slave_tx i_dut (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SCL_I(scl), .SDA_I(sda), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .ARB_LOST(ARB_LOST), .SLEEP(SLEEP), .WAKE(WAKE),
    .MST_START(MST_START), .IRQ(IRQ));
  tws_master_model i_mst (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    chk(RDATA, e);
  endtask : rc
  task automatic wait_irq;
    int n;
    n = 0;
    @(negedge MCLK);
    while (IRQ !== 1'b1 && n < 400)
    begin
      @(negedge MCLK);
      n++;
    end
    if (IRQ !== 1'b1)
    begin
      bad_count++;
      end_of_test();
    end
  endtask : wait_irq
  task automatic adr(input logic [7:0] ab, input logic e);
    i_mst.start_c();
    fork
      i_mst.xfer(ab, 1'b1, rv, ak);
      if (e)
        wait_irq();
    join
    chk({7'h00, ak}, {7'h00, !e});
  endtask : adr
  task automatic byte_rd(input logic [7:0] v, input logic [7:0] c, input logic ma,
    input logic [7:0] st);
    fork
      i_mst.xfer(8'hff, ma, rv, ak);
      begin
        wr(3'h0, v);
        wr(3'h2, c);
        wait_irq();
      end
    join
    chk(rv, v);
    rc(3'h3, st);
  endtask : byte_rd
  initial
  begin
    repeat (6) @(posedge MCLK);
    RESET_N <= 1'b1;
    rc(3'h3, 8'hf8);
    rc(3'h0, 8'hff);
    rc(3'h1, 8'h00);
    rc(3'h2, 8'h00);
    rc(3'h7, 8'h00);
    own = 7'($random(seed)) | 7'h40;
    wr(3'h1, {own, 1'b0});
    wr(3'h2, 8'h45);
    // data write with the flag clear collides
    wr(3'h0, 8'h3c);
    rc(3'h4, 8'h04);
    chk({7'h00, IRQ}, 8'h00);
    wr(3'h6, 8'h04);
    @(negedge MCLK);
    chk({7'h00, IRQ}, 8'h01);
    wr(3'h5, 8'h04);
    @(negedge MCLK);
    chk({7'h00, IRQ}, 8'h00);
    wr(3'h6, 8'h00);
    adr({own ^ 7'h01, 1'b1}, 1'b0);
    i_mst.stop_c();
    adr({own, 1'b1}, 1'b1);
    rc(3'h3, 8'ha8);
    byte_rd(8'($random(seed)), 8'hc5, 1'b0, 8'hb8);
    byte_rd(8'h01, 8'h85, 1'b1, 8'hc0);
    wr(3'h2, 8'hc5);
    i_mst.stop_c();
    @(posedge MCLK);
    ARB_LOST <= 1'b1;
    @(posedge MCLK);
    ARB_LOST <= 1'b0;
    adr({own, 1'b1}, 1'b1);
    rc(3'h3, 8'hb0);
    byte_rd(8'h80, 8'h85, 1'b0, 8'hc8);
    wr(3'h2, 8'he5);
    i_mst.xfer(8'hff, 1'b0, rv, ak);
    chk(rv, 8'hff);
    i_mst.stop_c();
    chk(8'(starts), 8'h01);
    wr(3'h2, 8'h05);
    adr({own, 1'b1}, 1'b0);
    i_mst.stop_c();
    wr(3'h2, 8'h45);
    SLEEP <= 1'b1;
    adr({own, 1'b1}, 1'b1);
    chk({6'h00, WAKE, SCL_OE}, 8'h03);
    @(posedge MCLK) SLEEP <= 1'b0;
    byte_rd(8'($random(seed)), 8'h85, 1'b1, 8'hc0);
    wr(3'h2, 8'hc5);
    i_mst.stop_c();
    wr(3'h1, {own, 1'b1});
    adr(8'h00, 1'b1);
    rc(3'h3, 8'h70);
    wr(3'h2, 8'hc5);
    i_mst.stop_c();
    wr(3'h1, {own, 1'b0});
    adr(8'h00, 1'b0);
    i_mst.stop_c();
    // an own address of zero must not turn the general call into a match
    wr(3'h1, 8'h00);
    adr(8'h00, 1'b0);
    i_mst.stop_c();
    chk(8'(i_mst.stuck), 8'h00);
    end_of_test();
  end
endmodule : tws_slave_tx_test
